// ---- tb/reg_file_model.sv ----
// register file model that supplies the base registers to the address generator
`timescale 1ns/1ps

module reg_file_model (
  input  wire logic        clock,
  input  wire logic        load,
  input  wire logic [15:0] base_word_in,
  input  wire logic [15:0] base_pointer_in,
  output logic      [15:0] base_word_reg,
  output logic      [15:0] base_pointer_reg
);
  // ==========================================
  // storage
  // loads land on the rising edge, so a request in the same cycle still sees the old values
  initial
  begin
    base_word_reg    = 16'h0000;
    base_pointer_reg = 16'h0000;
  end

  always @(posedge clock)
  begin
    if (load)
    begin
      base_word_reg    <= base_word_in;
      base_pointer_reg <= base_pointer_in;
    end
  end
endmodule

// ---- tb/tb_operand_effective_address_gen.sv ----
// self-checking testbench for the operand effective address generator
`timescale 1ns/1ps
`include "ea_regs.svh"

module tb_operand_effective_address_gen;
  // ==========================================
  // signals
  logic clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0, base_sel = 1'b0, index_sel = 1'b0;
  logic disp_is_byte = 1'b0, word_op = 1'b0, pop_value = 1'b0, bit_field_op = 1'b0, block_dst = 1'b0;
  logic rep_active = 1'b0, direction_flag = 1'b0, seg_override_valid = 1'b0, idx_wr_en = 1'b0, load = 1'b0;
  logic [1:0] ptr_sel = 2'h0, idx_wr_sel = 2'h0;
  logic [7:0] disp_low = 8'h00, disp_high = 8'h00;
  logic [3:0] nibble_literal = 4'h0;
  logic [15:0] idx_wr_data = 16'h0000, base_word_in = 16'h0000, base_pointer_in = 16'h0000;
  logic [15:0] base_word_reg, base_pointer_reg;
  logic [15:0] ea_offset_r, operand_value_r, src_r, dst_r, count_r, exp;
  logic ea_valid_r, operand_is_imm_r, rep_done_r;
  logic [3:0] field_length_r;
  ea_pkg::mode_t mode = ea_pkg::MODE_DIRECT;
  ea_pkg::seg_t seg_override = ea_pkg::SEG_DATA0, segment_r;
  int errors = 0, compares = 0;

  always #50 clock = ~clock;

  reg_file_model reg_file_model_inst (.clock(clock), .load(load), .base_word_in(base_word_in),
    .base_pointer_in(base_pointer_in), .base_word_reg(base_word_reg), .base_pointer_reg(base_pointer_reg));

  operand_effective_address_gen operand_effective_address_gen_inst (.clock(clock), .reset_n(reset_n),
    .req_valid(req_valid), .mode(mode), .ptr_sel(ptr_sel), .base_sel(base_sel), .index_sel(index_sel),
    .disp_low(disp_low), .disp_high(disp_high), .disp_is_byte(disp_is_byte), .word_op(word_op),
    .pop_value(pop_value), .bit_field_op(bit_field_op), .nibble_literal(nibble_literal),
    .block_dst(block_dst), .rep_active(rep_active), .direction_flag(direction_flag),
    .seg_override_valid(seg_override_valid), .seg_override(seg_override), .base_word_reg(base_word_reg),
    .base_pointer_reg(base_pointer_reg), .idx_wr_en(idx_wr_en), .idx_wr_sel(idx_wr_sel),
    .idx_wr_data(idx_wr_data), .ea_valid_r(ea_valid_r), .ea_offset_r(ea_offset_r),
    .operand_value_r(operand_value_r), .operand_is_imm_r(operand_is_imm_r), .field_length_r(field_length_r),
    .segment_r(segment_r), .rep_done_r(rep_done_r), .src_r(src_r), .dst_r(dst_r), .count_r(count_r));

  // ==========================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // request stays high so back-to-back calls keep it up; idle drops it
  task automatic req(input ea_pkg::mode_t m);
    mode = m;
    req_valid = 1'b1;
    @(negedge clock);
  endtask

  task automatic idle();
    req_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    idx_wr_en = 1'b1;
    idx_wr_sel = sel;
    idx_wr_data = d;
    @(negedge clock);
    idx_wr_en = 1'b0;
    @(negedge clock);
  endtask

  task automatic final_report();
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_immediate();
    {disp_high, disp_low, bit_field_op, nibble_literal} = {16'h7a85, 1'b1, 4'hb};
    for (int i = 0; i < 3; i++)
    begin
      word_op = (i == 1);
      pop_value = (i == 2);
      req(ea_pkg::MODE_IMMEDIATE);
      check(operand_value_r, (i == 0) ? 16'h0085 : 16'h7a85);
      check(operand_is_imm_r, 16'h0001);
      check(field_length_r, 16'h000b);
      idle();
    end
    bit_field_op = 1'b0;
  endtask

  task automatic t_direct_indirect();
    {disp_high, disp_low} = 16'h1234;
    req(ea_pkg::MODE_DIRECT);
    check(ea_offset_r, 16'h1234);
    check(segment_r, ea_pkg::SEG_DATA0);
    check(field_length_r, 16'h0000);
    idle();
    wr(`EA_PTR_SRC, 16'h1111);
    wr(`EA_PTR_DST, 16'h2222);
    check(dst_r, 16'h2222);
    for (int i = 0; i < 4; i++)
    begin
      ptr_sel = i[1:0];
      req(ea_pkg::MODE_INDIRECT);
      // the illegal pointer code gives no answer and leaves the last offset standing
      check(ea_valid_r, (i == 3) ? 16'h0000 : 16'h0001);
      check(ea_offset_r, (i == 0) ? 16'h1111 : (i == 1) ? 16'h2222 : 16'h3000);
      idle();
    end
  endtask

  task automatic t_block();
    wr(`EA_PTR_SRC, 16'h0100);
    wr(`EA_PTR_COUNT, 16'h0002);
    {word_op, rep_active, seg_override_valid} = 3'b111;
    seg_override = ea_pkg::SEG_PROGRAM;
    for (int i = 0; i < 3; i++)
    begin
      req(ea_pkg::MODE_BLOCK);
      check(ea_valid_r, (i < 2) ? 16'h0001 : 16'h0000);
      check(rep_done_r, (i == 0) ? 16'h0000 : 16'h0001);
      check(count_r, (i == 0) ? 16'h0001 : 16'h0000);
      check(src_r, (i == 0) ? 16'h0102 : 16'h0104);
      // a stopped repeat gives no answer, so the last offset stays
      check(ea_offset_r, (i == 0) ? 16'h0100 : 16'h0102);
    end
    idle();
    wr(`EA_PTR_DST, 16'h0200);
    {word_op, rep_active, block_dst, direction_flag} = 4'b0011;
    req(ea_pkg::MODE_BLOCK);
    check(ea_offset_r, 16'h0200);
    check(dst_r, 16'h01ff);
    check(src_r, 16'h0104);
    check(segment_r, ea_pkg::SEG_DATA1);
    idle();
    {block_dst, direction_flag, seg_override_valid} = 3'b000;
  endtask

  task automatic t_displacement();
    wr(`EA_PTR_SRC, 16'h0010);
    wr(`EA_PTR_DST, 16'h0020);
    {disp_low, disp_is_byte, index_sel} = {8'hfe, 2'b10};
    req(ea_pkg::MODE_INDEXED);
    check(ea_offset_r, 16'h000e);
    idle();
    {disp_high, disp_low, disp_is_byte, base_sel} = {16'h0020, 2'b00};
    req(ea_pkg::MODE_BASED);
    check(ea_offset_r, 16'h0010);
    check(segment_r, ea_pkg::SEG_STACK);
    idle();
    seg_override_valid = 1'b1;
    seg_override = ea_pkg::SEG_DATA1;
    req(ea_pkg::MODE_BASED);
    check(segment_r, ea_pkg::SEG_DATA1);
    idle();
    {seg_override_valid, disp_low, disp_is_byte} = {1'b0, 8'h80, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      {base_sel, index_sel} = i[1:0];
      exp = (base_sel ? 16'h3000 : 16'hfff0) + (index_sel ? 16'h0020 : 16'h0010) + 16'hff80;
      req(ea_pkg::MODE_BASED_INDEXED);
      check(ea_offset_r, exp);
      idle();
    end
  endtask

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    {load, base_word_in, base_pointer_in} = {1'b1, 16'h3000, 16'hfff0};
    @(negedge clock);
    load = 1'b0;
    t_immediate();
    t_direct_indirect();
    t_block();
    t_displacement();
    final_report();
  end

  initial
  begin
    repeat (2000) @(posedge clock);
    errors++;
    final_report();
  end
endmodule

// ---- verilog/ea_pkg.sv ----
// types shared by the operand effective address generator
package ea_pkg;

  typedef enum logic [6:0] {
    MODE_IMMEDIATE     = 7'h01,
    MODE_DIRECT        = 7'h02,
    MODE_INDIRECT      = 7'h04,
    MODE_BLOCK         = 7'h08,
    MODE_INDEXED       = 7'h10,
    MODE_BASED         = 7'h20,
    MODE_BASED_INDEXED = 7'h40
  } mode_t;

  typedef enum logic [1:0] {
    SEG_DATA0   = 2'h0,
    SEG_STACK   = 2'h1,
    SEG_DATA1   = 2'h2,
    SEG_PROGRAM = 2'h3
  } seg_t;

endpackage

// ---- verilog/ea_regs.svh ----
// constants for the operand effective address generator
// How it works
// - immediate operand comes from one or two instruction bytes; pop count always 16-bit
// - direct mode uses the 16-bit instruction address field as the offset
// - bit-field operations accept a 4-bit literal giving the field length
// - register-indirect selects source index, destination index or base word as offset
// - block operands are addressed with the current index value, modified afterwards
// - after each block element the index steps by one (byte) or two (word)
// - block source always uses source index, block destination always destination index
// - repeated block operations count down the count word, stopping when exhausted
// - indexed mode adds a signed displacement to the source or destination index
// - based mode adds a signed displacement to base pointer or base word
// - based-indexed sums displacement, one base register and one index register
// - any base register may pair with any index register
// - base pointer use selects the stack segment unless a prefix overrides it
// - a one-byte displacement is sign-extended to 16 bits before adding
`ifndef EA_REGS_SVH
`define EA_REGS_SVH

// ==========================================
// pointer select codes for indirect mode and index write port
`define EA_PTR_SRC    2'h0
`define EA_PTR_DST    2'h1
`define EA_PTR_BASE   2'h2
`define EA_PTR_COUNT  2'h3

// ==========================================
// reset values and step sizes
`define EA_INDEX_RESET 16'h0000
`define EA_COUNT_RESET 16'h0000
`define EA_STEP_BYTE   16'h0001
`define EA_STEP_WORD   16'h0002
`define EA_COUNT_ONE   16'h0001
`define EA_ZERO16      16'h0000

`endif

// ---- verilog/operand_effective_address_gen.sv ----
// operand effective address generator with block index stepping
`timescale 1ns/1ps
`include "ea_regs.svh"

module operand_effective_address_gen (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          req_valid,
  input  ea_pkg::mode_t      mode,
  input  wire logic [1:0]    ptr_sel,
  input  wire logic          base_sel,
  input  wire logic          index_sel,
  input  wire logic [7:0]    disp_low,
  input  wire logic [7:0]    disp_high,
  input  wire logic          disp_is_byte,
  input  wire logic          word_op,
  input  wire logic          pop_value,
  input  wire logic          bit_field_op,
  input  wire logic [3:0]    nibble_literal,
  input  wire logic          block_dst,
  input  wire logic          rep_active,
  input  wire logic          direction_flag,
  input  wire logic          seg_override_valid,
  input  ea_pkg::seg_t       seg_override,
  input  wire logic [15:0]   base_word_reg,
  input  wire logic [15:0]   base_pointer_reg,
  input  wire logic          idx_wr_en,
  input  wire logic [1:0]    idx_wr_sel,
  input  wire logic [15:0]   idx_wr_data,
  output logic               ea_valid_r,
  output logic [15:0]        ea_offset_r,
  output logic [15:0]        operand_value_r,
  output logic               operand_is_imm_r,
  output logic [3:0]         field_length_r,
  output ea_pkg::seg_t       segment_r,
  output logic               rep_done_r,
  output logic [15:0]        src_r,
  output logic [15:0]        dst_r,
  output logic [15:0]        count_r
);

  // ==========================================
  // operand selection
  logic [15:0]   offset_sel;
  logic          hit_sel;
  logic          imm_sel;
  ea_pkg::seg_t  seg_sel;

  wire [15:0] disp_ext   = disp_is_byte ? {{8{disp_low[7]}}, disp_low} : {disp_high, disp_low};
  wire [15:0] base_val   = base_sel ? base_word_reg : base_pointer_reg;
  wire [15:0] index_val  = index_sel ? dst_r : src_r;
  wire [15:0] ptr_val    = (ptr_sel == `EA_PTR_DST)  ? dst_r :
                           (ptr_sel == `EA_PTR_BASE) ? base_word_reg : src_r;
  wire        imm_word   = word_op | pop_value;
  wire [15:0] imm_val    = imm_word ? {disp_high, disp_low} : {8'h00, disp_low};
  wire [15:0] step       = word_op ? `EA_STEP_WORD : `EA_STEP_BYTE;
  wire [15:0] blk_reg    = block_dst ? dst_r : src_r;
  wire [15:0] blk_next   = direction_flag ? blk_reg - step : blk_reg + step;
  wire        is_block   = req_valid && (mode == ea_pkg::MODE_BLOCK);
  wire        count_zero = (count_r == `EA_ZERO16);
  wire        rep_stop   = is_block && rep_active && count_zero;
  wire        elem_go    = is_block && !rep_stop;
  wire        bp_used    = !base_sel && ((mode == ea_pkg::MODE_BASED) || (mode == ea_pkg::MODE_BASED_INDEXED));

  always_comb
  begin
    offset_sel = `EA_ZERO16;
    hit_sel    = 1'b1;
    imm_sel    = 1'b0;
    unique case (mode)
      ea_pkg::MODE_IMMEDIATE:     imm_sel = 1'b1;
      ea_pkg::MODE_DIRECT:        offset_sel = {disp_high, disp_low};
      ea_pkg::MODE_INDIRECT:
      begin
        offset_sel = ptr_val;
        hit_sel    = (ptr_sel != `EA_PTR_COUNT);
      end
      ea_pkg::MODE_BLOCK:
      begin
        offset_sel = blk_reg;
        hit_sel    = !rep_stop;
      end
      ea_pkg::MODE_INDEXED:       offset_sel = index_val + disp_ext;
      ea_pkg::MODE_BASED:         offset_sel = base_val + disp_ext;
      ea_pkg::MODE_BASED_INDEXED: offset_sel = base_val + index_val + disp_ext;
      default:                    hit_sel = 1'b0;
    endcase
  end

  // block destination segment cannot be overridden; everything else honours the prefix
  always_comb
  begin
    if (mode == ea_pkg::MODE_BLOCK && block_dst)
      seg_sel = ea_pkg::SEG_DATA1;
    else if (seg_override_valid)
      seg_sel = seg_override;
    else if (bp_used)
      seg_sel = ea_pkg::SEG_STACK;
    else
      seg_sel = ea_pkg::SEG_DATA0;
  end

  // ==========================================
  // index and count registers; hardware stepping wins over a same-cycle write
  wire        src_step  = elem_go && !block_dst;
  wire        dst_step  = elem_go && block_dst;
  wire        cnt_step  = elem_go && rep_active;
  wire [15:0] src_nxt   = src_step ? blk_next :
                          (idx_wr_en && idx_wr_sel == `EA_PTR_SRC) ? idx_wr_data : src_r;
  wire [15:0] dst_nxt   = dst_step ? blk_next :
                          (idx_wr_en && idx_wr_sel == `EA_PTR_DST) ? idx_wr_data : dst_r;
  wire [15:0] count_nxt = cnt_step ? count_r - `EA_COUNT_ONE :
                          (idx_wr_en && idx_wr_sel == `EA_PTR_COUNT) ? idx_wr_data : count_r;
  wire        rep_done_nxt = is_block && rep_active && (count_zero || count_r == `EA_COUNT_ONE);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      src_r   <= `EA_INDEX_RESET;
      dst_r   <= `EA_INDEX_RESET;
      count_r <= `EA_COUNT_RESET;
    end
    else
    begin
      src_r   <= src_nxt;
      dst_r   <= dst_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================
  // answer registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ea_valid_r       <= 1'b0;
      ea_offset_r      <= `EA_ZERO16;
      operand_value_r  <= `EA_ZERO16;
      operand_is_imm_r <= 1'b0;
      field_length_r   <= 4'h0;
      segment_r        <= ea_pkg::SEG_DATA0;
      rep_done_r       <= 1'b0;
    end
    else
    begin
      ea_valid_r <= req_valid && hit_sel;
      rep_done_r <= rep_done_nxt;
      if (req_valid && hit_sel)
      begin
        ea_offset_r      <= offset_sel;
        operand_value_r  <= imm_sel ? imm_val : `EA_ZERO16;
        operand_is_imm_r <= imm_sel;
        field_length_r   <= bit_field_op ? nibble_literal : 4'h0;
        segment_r        <= seg_sel;
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_imm_operand: assert property (
    req_valid && mode == ea_pkg::MODE_IMMEDIATE |=> ea_valid_r && operand_is_imm_r &&
      operand_value_r == ($past(imm_word) ? {$past(disp_high), $past(disp_low)} : {8'h00, $past(disp_low)}))
    else $error("immediate operand value wrong");

  chk_direct_offset: assert property (
    req_valid && mode == ea_pkg::MODE_DIRECT |=> ea_valid_r && ea_offset_r == {$past(disp_high), $past(disp_low)})
    else $error("direct offset wrong");

  chk_field_length: assert property (
    req_valid && hit_sel && bit_field_op |=> field_length_r == $past(nibble_literal))
    else $error("bit field length not captured");

  chk_indirect_base: assert property (
    req_valid && mode == ea_pkg::MODE_INDIRECT && ptr_sel == `EA_PTR_BASE |=> ea_offset_r == $past(base_word_reg))
    else $error("indirect base word offset wrong");

  chk_post_modify: assert property (
    src_step |=> ea_offset_r == $past(src_r) && src_r == $past(blk_next))
    else $error("source block not post-modified");

  chk_word_step_up: assert property (
    src_step && word_op && !direction_flag |=> src_r == $past(src_r) + 16'h0002)
    else $error("word upward step wrong");

  chk_byte_step_down: assert property (
    dst_step && !word_op && direction_flag |=> dst_r == $past(dst_r) - 16'h0001)
    else $error("byte downward step wrong");

  chk_dst_block: assert property (
    dst_step |=> ea_offset_r == $past(dst_r) && segment_r == ea_pkg::SEG_DATA1)
    else $error("destination block addressing wrong");

  chk_count_stop: assert property (
    rep_stop |=> !ea_valid_r && rep_done_r && count_r == 16'h0000)
    else $error("exhausted repeat not stopped");

  chk_indexed_sum: assert property (
    req_valid && mode == ea_pkg::MODE_INDEXED |=> ea_offset_r == $past(index_val) + $past(disp_ext))
    else $error("indexed offset wrong");

  chk_sign_extend: assert property (
    req_valid && mode == ea_pkg::MODE_INDEXED && disp_is_byte |=>
      ea_offset_r == 16'($past(index_val) + {{8{$past(disp_low[7])}}, $past(disp_low)}))
    else $error("byte displacement not sign-extended");

  chk_based_sum: assert property (
    req_valid && mode == ea_pkg::MODE_BASED && !base_sel |=>
      ea_offset_r == 16'($past(base_pointer_reg) + $past(disp_ext)))
    else $error("based offset wrong");

  chk_based_indexed: assert property (
    req_valid && mode == ea_pkg::MODE_BASED_INDEXED |=>
      ea_offset_r == 16'($past(base_val) + $past(index_val) + $past(disp_ext)))
    else $error("based indexed offset wrong");

  chk_bp_stack: assert property (
    req_valid && bp_used && !seg_override_valid |=> segment_r == ea_pkg::SEG_STACK)
    else $error("base pointer default segment wrong");

  cov_rep_run: cover property (cnt_step ##1 cnt_step ##1 rep_stop);
  cov_based_bp: cover property (req_valid && mode == ea_pkg::MODE_BASED && bp_used);
  cov_wrap: cover property (req_valid && mode == ea_pkg::MODE_BASED_INDEXED && offset_sel < base_val);
  cov_imm_pop: cover property (req_valid && mode == ea_pkg::MODE_IMMEDIATE && pop_value && !word_op);

endmodule
